// *** verification/sgc_top_bench.sv ***
// self-checking bench for the switch global control registers
module sgc_top_bench
    import sgc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals, table and helpers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  c1;                   // ctrl one value
        logic [7:0]  c2;                   // ctrl two value
        logic        err;                  // errored frame
        logic [15:0] lf;                   // length/type field
        logic [15:0] dl;                   // actual data length
        logic [15:0] sz;                   // frame size
        logic        ku;                   // known unicast
        logic        cx;                   // crosses port-vlan
        logic        fwd;                  // expected decision
    } sgc_row_t;
    logic        i_clk, rst, psel, penable, pwrite, flow, boff, an_tx, an_rx; // drives
    logic        fv, fe, fk, fc, o_pready, o_pslverr, o_frm_done, o_frm_fwd; // frame side and apb answer
    logic        o_tx_pause_en, o_rx_pause_en, o_pass_all, o_jumbo_2k_en;     // controls
    logic        o_aggr_backoff_en, o_aging_en, o_fast_age, o_age_tick;       // controls
    logic [7:0]  paddr;                    // apb address
    logic [31:0] pwdata, o_prdata, rdat;   // apb data, last read
    logic        rerr;                     // last error flag
    logic [15:0] flf, fdl, fsz;            // frame fields
    int          mismatches, samples_checked, cycles, gap, n; // bookkeeping
    sgc_row_t    rows [15];                // ordinary cases
    sgc_top #(.FAST_AGE_CYC(35'h14), .NORM_AGE_CYC(35'h32)) dut (.i_clk(i_clk),
        .i_sys_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata),
        .o_pslverr(o_pslverr), .i_flow_control_strap_pin(flow), .i_backoff_strap_pin(boff),
        .i_an_tx_pause(an_tx), .i_an_rx_pause(an_rx), .i_frm_valid(fv), .i_frm_err(fe),
        .i_frm_len_field(flf), .i_frm_data_len(fdl), .i_frm_size(fsz),
        .i_frm_known_ucast(fk), .i_frm_cross_vlan(fc), .o_frm_done(o_frm_done),
        .o_frm_fwd(o_frm_fwd), .o_tx_pause_en(o_tx_pause_en), .o_rx_pause_en(o_rx_pause_en),
        .o_pass_all(o_pass_all), .o_jumbo_2k_en(o_jumbo_2k_en),
        .o_aggr_backoff_en(o_aggr_backoff_en), .o_aging_en(o_aging_en),
        .o_fast_age(o_fast_age), .o_age_tick(o_age_tick));
    // clock, 10 ns period
    initial begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end
    // hang guard, far above the expected run length
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer: setup, then access held until pready seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, wr, a, d};
        @(posedge i_clk);
        penable <= 1'h1;
        do @(posedge i_clk); while (o_pready !== 1'h1);
        {rdat, rerr} = {o_prdata, o_pslverr};
        {psel, penable} <= 2'h0;
    endtask
    // reset with given strap levels, then check defaults
    task automatic do_reset(input logic fs, input logic bs, input logic [31:0] exp1);
        {flow, boff, an_tx, an_rx, rst} <= {fs, bs, 3'h7};
        repeat (8) @(posedge i_clk);
        rst <= 1'h0;
        repeat (3) @(posedge i_clk);
        apb(1'h0, SGC_ADDR_CTRL_ONE, 32'h0);
        check("ctrl_one_rst", rdat, exp1);
        apb(1'h0, SGC_ADDR_CTRL_TWO, 32'h0);
        check("ctrl_two_rst", rdat, 32'h80);
        check("tx_pause_rst", 32'(o_tx_pause_en), 32'(!fs));
    endtask
    // interval between two aging pulses
    task automatic age_gap();
        n = 0;
        do begin @(negedge i_clk); n++; end while (o_age_tick !== 1'h1 && n < 200);
        gap = 0;
        do begin @(negedge i_clk); gap++; end while (o_age_tick !== 1'h1 && gap < 200);
    endtask
    // counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, fv, fe, fk, fc} = '0;
        {flf, fdl, fsz, mismatches, samples_checked, cycles} = '0;
        {flow, boff, an_tx, an_rx, rst} = 5'h1F;
        rows = '{'{8'h04,8'h80,1'h0,16'h0800,16'h0000,16'h0040,1'h1,1'h0,1'h1},
            '{8'h04,8'h80,1'h1,16'h0800,16'h0000,16'h0040,1'h1,1'h0,1'h0},
            '{8'h84,8'h80,1'h1,16'h0064,16'h0063,16'h0801,1'h1,1'h0,1'h1},
            '{8'h04,8'h80,1'h0,16'h0800,16'h0000,16'h0601,1'h1,1'h0,1'h0},
            '{8'h44,8'h80,1'h0,16'h0800,16'h0000,16'h0800,1'h1,1'h0,1'h1},
            '{8'h44,8'h80,1'h0,16'h0800,16'h0000,16'h0801,1'h1,1'h0,1'h0},
            '{8'h0C,8'h80,1'h0,16'h0064,16'h0063,16'h0040,1'h1,1'h0,1'h0},
            '{8'h0C,8'h80,1'h0,16'h0064,16'h0064,16'h0040,1'h1,1'h0,1'h1},
            '{8'h0C,8'h80,1'h0,16'h05DC,16'h0000,16'h0040,1'h1,1'h0,1'h1},
            '{8'h0C,8'h80,1'h0,16'h05DB,16'h0000,16'h0040,1'h1,1'h0,1'h0},
            '{8'h06,8'h80,1'h0,16'h0064,16'h0063,16'h0040,1'h1,1'h0,1'h1},
            '{8'h07,8'h80,1'h0,16'h0800,16'h0000,16'h0040,1'h1,1'h1,1'h0},
            '{8'h04,8'h00,1'h0,16'h0800,16'h0000,16'h0040,1'h1,1'h1,1'h1},
            '{8'h04,8'h00,1'h0,16'h0800,16'h0000,16'h0040,1'h0,1'h1,1'h0},
            '{8'h84,8'h80,1'h0,16'h0800,16'h0000,16'h0040,1'h1,1'h1,1'h0}};
        do_reset(1'h1, 1'h0, 32'h34);
        foreach (rows[i]) begin
            apb(1'h1, SGC_ADDR_CTRL_ONE, {24'h0, rows[i].c1});
            apb(1'h1, SGC_ADDR_CTRL_TWO, {24'h0, rows[i].c2});
            apb(1'h0, SGC_ADDR_CTRL_ONE, 32'h0);
            check("ctrl_one", rdat, {24'h0, rows[i].c1});
            check("ctrl_outs", 32'({o_pass_all, o_jumbo_2k_en, o_aging_en, o_fast_age,
                o_aggr_backoff_en}), 32'({rows[i].c1[7:6], rows[i].c1[2:0]}));
            {fv, fe, flf, fdl, fsz, fk, fc} <= {1'h1, rows[i][51:1]};
            @(posedge i_clk);
            fv <= 1'h0;
            @(negedge i_clk);
            check("frm_done", 32'(o_frm_done), 32'h1);
            check("frm_fwd", 32'(o_frm_fwd), 32'(rows[i].fwd));
        end
        // each pause disable works alone, enable follows negotiation
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h24);
        repeat (2) @(negedge i_clk);
        check("pause", 32'({o_tx_pause_en, o_rx_pause_en}), 32'h1);
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h14);
        repeat (2) @(negedge i_clk);
        check("pause", 32'({o_tx_pause_en, o_rx_pause_en}), 32'h2);
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h04);
        an_tx <= 1'h0;
        repeat (2) @(negedge i_clk);
        check("pause", 32'({o_tx_pause_en, o_rx_pause_en}), 32'h1);
        // unmapped place refused, unused ctrl two bits read zero
        apb(1'h1, 8'h14, 32'hFF);
        apb(1'h0, 8'h14, 32'h0);
        check("unmapped", {rdat[30:0], rerr}, 32'h1);
        apb(1'h1, SGC_ADDR_CTRL_TWO, 32'hFF);
        apb(1'h0, SGC_ADDR_CTRL_TWO, 32'h0);
        check("ctrl_two", rdat, 32'h80);
        apb(1'h0, SGC_ADDR_CTRL_ONE, 32'h0);
        check("ctrl_one", rdat, 32'h04);
        // aging intervals: fast, normal, then none while disabled
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h06);
        age_gap();
        check("fast_gap", 32'(gap), 32'h14);
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h04);
        age_gap();
        check("norm_gap", 32'(gap), 32'h32);
        apb(1'h1, SGC_ADDR_CTRL_ONE, 32'h00);
        n = 0;
        repeat (120) begin @(negedge i_clk); n += int'(o_age_tick === 1'h1); end
        check("no_ticks", 32'(n), 32'h0);
        do_reset(1'h0, 1'h1, 32'h05);
        summarize();
    end
endmodule

// *** verilog/sgc_age_tick.sv ***
// aging tick generator: one pulse per aging interval
module sgc_age_tick
    import sgc_pkg::*;
#(
    parameter logic [SGC_AGE_W-1:0] FAST_CYC = SGC_AGE_W'(SGC_FAST_AGE_CYC), // fast interval
    parameter logic [SGC_AGE_W-1:0] NORM_CYC = SGC_AGE_W'(SGC_NORM_AGE_CYC)  // normal interval
)(
    input  wire logic i_clk,              // core clock
    input  wire logic i_sys_rst,          // async reset, active high
    input  wire logic i_enable,           // aging enabled
    input  wire logic i_fast,             // fast interval selected
    output logic      o_tick              // one-cycle aging pulse
);
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [SGC_AGE_W-1:0] cnt_r, cnt_nxt; // cycles since last tick
    logic                 tick_r, tick_nxt; // tick pulse
    logic [SGC_AGE_W-1:0] limit;          // active interval

    // next values: count while enabled, wrap at interval
    always_comb begin
        limit    = i_fast ? FAST_CYC : NORM_CYC;
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!i_enable) begin
            cnt_nxt = '0;                 // disabled: hold cleared
        end else if (cnt_r >= limit - SGC_AGE_W'(1)) begin
            cnt_nxt  = '0;                // interval elapsed
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + SGC_AGE_W'(1);
        end
    end

    // registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_tick = tick_r;
endmodule

// *** verilog/sgc_pkg.sv ***
// constants shared by the switch global control block
package sgc_pkg;
    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SGC_IDX_CTRL_ONE  = 8'h03;               // global_control_one index
    localparam logic [7:0] SGC_IDX_CTRL_TWO  = 8'h04;               // global_control_two index
    localparam logic [7:0] SGC_ADDR_CTRL_ONE = 8'(SGC_IDX_CTRL_ONE * 4); // byte address 0x0C
    localparam logic [7:0] SGC_ADDR_CTRL_TWO = 8'(SGC_IDX_CTRL_TWO * 4); // byte address 0x10

    // ------------------------------------------------------------
    // field positions, global_control_one
    // ------------------------------------------------------------
    localparam int SGC_B_PASS_ALL  = 7;                             // forward every frame not blocked by port-vlan
    localparam int SGC_B_JUMBO_2K  = 6;                             // 2k byte frames
    localparam int SGC_B_TX_FC_DIS = 5;                             // transmit pause off
    localparam int SGC_B_RX_FC_DIS = 4;                             // receive pause off
    localparam int SGC_B_LEN_CHK   = 3;                             // length field check
    localparam int SGC_B_AGE_EN    = 2;                             // aging enable
    localparam int SGC_B_FAST_AGE  = 1;                             // fast aging
    localparam int SGC_B_AGGR_BO   = 0;                             // aggressive back-off
    // field positions, global_control_two
    localparam int SGC_B_UCAST_PV  = 7;                             // unicast port-vlan

    // ------------------------------------------------------------
    // values after reset (strap bits filled in after release)
    // ------------------------------------------------------------
    localparam logic [7:0] SGC_RST_CTRL_ONE = 8'h04;                // only aging enabled
    localparam logic [7:0] SGC_RST_CTRL_TWO = 8'h80;                // vlan confinement on
    localparam logic [7:0] SGC_CTRL_TWO_RW  = 8'h80;                // implemented bits

    // ------------------------------------------------------------
    // frame limits
    // ------------------------------------------------------------
    localparam logic [15:0] SGC_LEN_FIELD_MAX = 16'd1500;           // below: length, else type
    localparam logic [15:0] SGC_SIZE_2K       = 16'd2048;           // 2k byte frame limit
    localparam logic [15:0] SGC_SIZE_STD      = 16'd1536;           // limit without 2k support

    // ------------------------------------------------------------
    // aging timing
    // ------------------------------------------------------------
    localparam longint SGC_CLK_MHZ      = 100;                      // core clock rate
    localparam longint SGC_FAST_AGE_US  = 800;                      // fast aging interval
    localparam longint SGC_NORM_AGE_S   = 300;                      // normal aging interval
    localparam longint SGC_FAST_AGE_CYC = SGC_FAST_AGE_US * SGC_CLK_MHZ;
    localparam longint SGC_NORM_AGE_CYC = SGC_NORM_AGE_S * 1000000 * SGC_CLK_MHZ;
    localparam int     SGC_AGE_W        = 35;                       // age counter width
endpackage

// *** verilog/sgc_strap_cap.sv ***
// strap capture: samples the strap pins once after reset release
module sgc_strap_cap
    import sgc_pkg::*;
(
    input  wire logic i_clk,              // core clock
    input  wire logic i_sys_rst,          // async reset, active high
    input  wire logic i_flow_strap,       // flow control strap level
    input  wire logic i_backoff_strap,    // back-off strap level
    output logic      o_load,             // one-cycle load pulse
    output logic      o_flow_dflt,        // captured flow strap
    output logic      o_backoff_dflt      // captured back-off strap
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic done_r, done_nxt;               // capture done
    logic load_r, load_nxt;               // load pulse
    logic flow_r, flow_nxt;               // flow strap value
    logic bo_r,   bo_nxt;                 // back-off strap value

    // next values: capture on the first edge after release
    always_comb begin
        done_nxt = 1'b1;
        load_nxt = ~done_r;
        flow_nxt = done_r ? flow_r : i_flow_strap;
        bo_nxt   = done_r ? bo_r   : i_backoff_strap;
    end

    // registers, constants only under reset
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            done_r <= 1'b0;
            load_r <= 1'b0;
            flow_r <= 1'b0;
            bo_r   <= 1'b0;
        end else begin
            done_r <= done_nxt;
            load_r <= load_nxt;
            flow_r <= flow_nxt;
            bo_r   <= bo_nxt;
        end
    end

    assign o_load         = load_r;
    assign o_flow_dflt    = flow_r;
    assign o_backoff_dflt = bo_r;
endmodule

// *** verilog/sgc_top.sv ***
// switch global control registers with apb slave and frame policy
//
// Behaviour
// [RULE1] pass-all bit forwards every frame, resets zero; the code still drops frames blocked by port-vlan confinement
// [RULE2] bit six enables 2k byte frames
// [RULE3] bit five forces transmit pause off
// [RULE4] bit four forces receive pause off
// [RULE5] flow disable bits default from strap pin
// [RULE6] length check drops mismatching short frames
// [RULE7] bit two enables aging, resets one
// [RULE8] bit one selects 800 us fast aging
// [RULE9] bit zero aggressive back-off, strap default
// [RULE10] unicast port-vlan bit confines all packets
// [RULE11] clear bit lets known unicast cross
// [RULE12] bits read back last written value; the code reads global_control_two bits six to zero as zero
//
// The APB interface to the registers was decided locally.
module sgc_top
    import sgc_pkg::*;
#(
    parameter logic [SGC_AGE_W-1:0] FAST_AGE_CYC = SGC_AGE_W'(SGC_FAST_AGE_CYC), // fast interval
    parameter logic [SGC_AGE_W-1:0] NORM_AGE_CYC = SGC_AGE_W'(SGC_NORM_AGE_CYC)  // normal interval
)(
    input  wire logic        i_clk,                   // core clock 100 mhz
    input  wire logic        i_sys_rst,               // async reset, active high
    // apb slave
    input  wire logic        i_psel,                  // apb select
    input  wire logic        i_penable,               // apb enable
    input  wire logic        i_pwrite,                // apb direction
    input  wire logic [7:0]  i_paddr,                 // apb byte address
    input  wire logic [31:0] i_pwdata,                // apb write data
    output logic             o_pready,                // apb ready
    output logic [31:0]      o_prdata,                // apb read data
    output logic             o_pslverr,               // apb error, unmapped
    // straps
    input  wire logic        i_flow_control_strap_pin, // flow disable strap
    input  wire logic        i_backoff_strap_pin,      // back-off strap
    // auto-negotiation result
    input  wire logic        i_an_tx_pause,           // link resolved tx pause
    input  wire logic        i_an_rx_pause,           // link resolved rx pause
    // frame under decision
    input  wire logic        i_frm_valid,             // frame decision request
    input  wire logic        i_frm_err,               // frame has an error
    input  wire logic [15:0] i_frm_len_field,         // length/type field
    input  wire logic [15:0] i_frm_data_len,          // actual data length
    input  wire logic [15:0] i_frm_size,              // total frame size
    input  wire logic        i_frm_known_ucast,       // known unicast destination
    input  wire logic        i_frm_cross_vlan,        // target outside port-vlan
    output logic             o_frm_done,              // decision pulse
    output logic             o_frm_fwd,               // forward, valid with done
    // control outputs
    output logic             o_tx_pause_en,           // transmit pause active
    output logic             o_rx_pause_en,           // receive pause active
    output logic             o_pass_all,              // debug pass-all mode
    output logic             o_jumbo_2k_en,           // 2k frames accepted
    output logic             o_aggr_backoff_en,       // aggressive back-off
    output logic             o_aging_en,              // aging enabled
    output logic             o_fast_age,              // fast aging selected
    output logic             o_age_tick               // aging pulse
);
    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // returns 1 when the address hits the given register
    function automatic logic sgc_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        sgc_hit = (addr == reg_addr);
    endfunction

    // ------------------------------------------------------------
    // register and bus state
    // ------------------------------------------------------------
    logic [7:0]  ctrl1_r, ctrl1_nxt;                  // global_control_one
    logic [7:0]  ctrl2_r, ctrl2_nxt;                  // global_control_two
    logic        pready_r, pready_nxt;                // ready in access phase
    logic [31:0] prdata_r, prdata_nxt;                // read data
    logic        pslverr_r, pslverr_nxt;              // error answer
    logic        strap_load;                          // strap load pulse
    logic        strap_flow;                          // captured flow strap
    logic        strap_bo;                            // captured back-off strap
    logic        setup;                               // apb setup cycle
    logic        commit;                              // access completes
    logic        hit1, hit2;                          // register hits

    assign setup  = i_psel & ~i_penable;
    assign commit = i_psel & i_penable & pready_r;
    assign hit1   = sgc_hit(i_paddr, SGC_ADDR_CTRL_ONE);
    assign hit2   = sgc_hit(i_paddr, SGC_ADDR_CTRL_TWO);

    // strap capture after reset release
    sgc_strap_cap u_strap (
        .i_clk           (i_clk),
        .i_sys_rst       (i_sys_rst),
        .i_flow_strap    (i_flow_control_strap_pin),
        .i_backoff_strap (i_backoff_strap_pin),
        .o_load          (strap_load),
        .o_flow_dflt     (strap_flow),
        .o_backoff_dflt  (strap_bo)
    );

    // ------------------------------------------------------------
    // apb answer: one wait-free access, data prepared in setup
    // ------------------------------------------------------------
    always_comb begin
        pready_nxt  = setup;                          // ready next cycle
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pslverr_nxt = ~(hit1 | hit2);             // unmapped address
            if (!i_pwrite) begin
                if (hit1) begin
                    prdata_nxt = {24'h000000, ctrl1_r}; // RULE12
                end else if (hit2) begin
                    prdata_nxt = {24'h000000, ctrl2_r}; // RULE12
                end else begin
                    prdata_nxt = 32'h00000000;        // unmapped reads zero
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_comb begin
        ctrl1_nxt = ctrl1_r;
        ctrl2_nxt = ctrl2_r;
        if (strap_load) begin
            ctrl1_nxt[SGC_B_TX_FC_DIS] = strap_flow;  // RULE5
            ctrl1_nxt[SGC_B_RX_FC_DIS] = strap_flow;  // RULE5
            ctrl1_nxt[SGC_B_AGGR_BO]   = strap_bo;    // RULE9
        end
        if (commit && i_pwrite && hit1) begin
            ctrl1_nxt = i_pwdata[7:0];                // RULE12
        end
        if (commit && i_pwrite && hit2) begin
            ctrl2_nxt = i_pwdata[7:0] & SGC_CTRL_TWO_RW; // RULE12
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl1_r <= SGC_RST_CTRL_ONE;              // RULE1 RULE2 RULE7 RULE8
            ctrl2_r <= SGC_RST_CTRL_TWO;              // RULE10
        end else begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
        end
    end

    // ------------------------------------------------------------
    // aging
    // ------------------------------------------------------------
    sgc_age_tick #(
        .FAST_CYC (FAST_AGE_CYC),
        .NORM_CYC (NORM_AGE_CYC)
    ) u_age (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_enable  (ctrl1_r[SGC_B_AGE_EN]),           // RULE7
        .i_fast    (ctrl1_r[SGC_B_FAST_AGE]),         // RULE8
        .o_tick    (o_age_tick)
    );

    // ------------------------------------------------------------
    // pause resolution and frame decision
    // ------------------------------------------------------------
    logic        txp_r, txp_nxt;                      // tx pause enable
    logic        rxp_r, rxp_nxt;                      // rx pause enable
    logic        done_r, done_nxt;                    // decision pulse
    logic        fwd_r, fwd_nxt;                      // forward result
    logic        len_bad;                             // length mismatch
    logic        too_big;                             // over size limit
    logic        vlan_block;                          // port-vlan confinement
    logic [15:0] size_max;                            // active size limit

    always_comb begin
        txp_nxt    = i_an_tx_pause & ~ctrl1_r[SGC_B_TX_FC_DIS]; // RULE3
        rxp_nxt    = i_an_rx_pause & ~ctrl1_r[SGC_B_RX_FC_DIS]; // RULE4
        size_max   = ctrl1_r[SGC_B_JUMBO_2K] ? SGC_SIZE_2K : SGC_SIZE_STD; // RULE2
        too_big    = (i_frm_size > size_max);
        len_bad    = ctrl1_r[SGC_B_LEN_CHK]
                   & (i_frm_len_field < SGC_LEN_FIELD_MAX)
                   & (i_frm_len_field != i_frm_data_len); // RULE6
        vlan_block = i_frm_cross_vlan
                   & (ctrl2_r[SGC_B_UCAST_PV] | ~i_frm_known_ucast); // RULE10 RULE11
        done_nxt   = i_frm_valid;
        fwd_nxt    = fwd_r;
        if (i_frm_valid) begin
            if (ctrl1_r[SGC_B_PASS_ALL]) begin
                fwd_nxt = ~vlan_block;                // RULE1
            end else begin
                fwd_nxt = ~(i_frm_err | len_bad | too_big | vlan_block);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            txp_r  <= 1'b0;
            rxp_r  <= 1'b0;
            done_r <= 1'b0;
            fwd_r  <= 1'b0;
        end else begin
            txp_r  <= txp_nxt;
            rxp_r  <= rxp_nxt;
            done_r <= done_nxt;
            fwd_r  <= fwd_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_pready          = pready_r;
    assign o_prdata          = prdata_r;
    assign o_pslverr         = pslverr_r;
    assign o_frm_done        = done_r;
    assign o_frm_fwd         = fwd_r;
    assign o_tx_pause_en     = txp_r;
    assign o_rx_pause_en     = rxp_r;
    assign o_pass_all        = ctrl1_r[SGC_B_PASS_ALL];
    assign o_jumbo_2k_en     = ctrl1_r[SGC_B_JUMBO_2K];
    assign o_aggr_backoff_en = ctrl1_r[SGC_B_AGGR_BO];
    assign o_aging_en        = ctrl1_r[SGC_B_AGE_EN];
    assign o_fast_age        = ctrl1_r[SGC_B_FAST_AGE];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking sgc_cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_pass_all_fwd: assert property (i_frm_valid && o_pass_all && !i_frm_cross_vlan
        |=> o_frm_done && o_frm_fwd) // RULE1
        else $error("pass-all frame not forwarded");
    a_size_limit: assert property (i_frm_valid && !o_pass_all && !o_jumbo_2k_en
        && i_frm_size > SGC_SIZE_STD |=> !o_frm_fwd) // RULE2
        else $error("oversize frame forwarded");
    a_tx_pause_off: assert property (ctrl1_r[SGC_B_TX_FC_DIS] |=> !o_tx_pause_en) // RULE3
        else $error("tx pause active while disabled");
    a_rx_pause_follow: assert property (!ctrl1_r[SGC_B_RX_FC_DIS]
        |=> o_rx_pause_en == $past(i_an_rx_pause)) // RULE4
        else $error("rx pause not following negotiation");
    a_strap_load: assert property (strap_load && !commit
        |=> ctrl1_r[SGC_B_TX_FC_DIS] == $past(strap_flow)
        && ctrl1_r[SGC_B_RX_FC_DIS] == $past(strap_flow)
        && ctrl1_r[SGC_B_AGGR_BO] == $past(strap_bo)) // RULE5 RULE9
        else $error("strap default not loaded");
    a_len_check: assert property (i_frm_valid && !o_pass_all && ctrl1_r[SGC_B_LEN_CHK]
        && i_frm_len_field < SGC_LEN_FIELD_MAX && i_frm_len_field != i_frm_data_len
        |=> !o_frm_fwd) // RULE6
        else $error("length mismatch forwarded");
    a_age_off: assert property (!o_aging_en [*2] |-> !o_age_tick) // RULE7
        else $error("age tick while aging disabled");
    a_vlan_confine: assert property (i_frm_valid && ctrl2_r[SGC_B_UCAST_PV] && i_frm_cross_vlan
        |=> !o_frm_fwd) // RULE10
        else $error("frame crossed port-vlan");
    a_vlan_mcast: assert property (i_frm_valid && !i_frm_known_ucast && i_frm_cross_vlan
        |=> !o_frm_fwd) // RULE11
        else $error("unknown or multicast crossed port-vlan");
    a_readback: assert property (setup && !i_pwrite && hit1 && !strap_load
        |=> o_prdata == {24'h000000, $past(ctrl1_r)} ##0 o_pready) // RULE12
        else $error("readback mismatch");

    c_write_one: cover property (commit && i_pwrite && hit1);
    c_read_two: cover property (commit && !i_pwrite && hit2);
    c_frame_drop: cover property (o_frm_done && !o_frm_fwd);
    c_age_tick: cover property (o_age_tick);
endmodule
